// ==== hdl/crmc_pkg.sv ====
// Purpose: shared constants for the clock/reset mode controller
// Assumes: one system clock domain at 25 MHz
// Notes: vector codes and field widths are used by the top and the tick unit
package crmc_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam logic [7:0] RST_DRIVE_CYC = 8'h80;
  localparam logic [7:0] RST_SYNC_CYC = 8'h03;
  localparam logic [7:0] RST_SAMPLE_CYC = 8'h40;
  localparam int TICK_RATE_W = 4;
  localparam int TICK_CNT_W = 16;
  localparam int WD_RATE_W = 3;
  localparam logic [1:0] VEC_POR_EXT = 2'h0;
  localparam logic [1:0] VEC_MONITOR = 2'h1;
  localparam logic [1:0] VEC_WATCHDOG = 2'h2;
  typedef enum logic [4:0] {
    CRMC_RUN   = 5'h01,
    CRMC_WAIT  = 5'h02,
    CRMC_STOP1 = 5'h04,
    CRMC_STOP2 = 5'h08,
    CRMC_STOP  = 5'h10
  } crmc_mode_e;
  typedef enum logic [3:0] {
    CRMC_RS_DRIVE  = 4'h1,
    CRMC_RS_SETTLE = 4'h2,
    CRMC_RS_HOLD   = 4'h4,
    CRMC_RS_DONE   = 4'h8
  } crmc_rst_e;
endpackage

// ==== hdl/crmc_tick.sv ====
// Purpose: periodic tick divider
// Assumes: count_en is the gated oscillator clock enable
// Notes: period is 2^(rate+2) enables for rates 1 to 13; rate zero stops the divider
`timescale 1ns/1ps
module crmc_tick
  import crmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic count_en,
  input wire logic restart,
  input wire logic [TICK_RATE_W-1:0] rate,
  output logic expire
);
  logic [TICK_CNT_W-1:0] cnt;

  function automatic logic [TICK_CNT_W-1:0] period_of(input logic [TICK_RATE_W-1:0] r);
    period_of = TICK_CNT_W'(({{(TICK_CNT_W-1){1'b0}}, 1'b1} << (r + 4'h2)) - 1);
  endfunction

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= '0;
      expire <= 1'b0;
    end
    else if (ce)
    begin
      expire <= 1'b0;
      if (restart || rate == '0)
        cnt <= '0;
      else if (count_en)
      begin
        if (cnt >= period_of(rate))
        begin
          cnt <= '0;
          expire <= 1'b1;
        end
        else
          cnt <= cnt + 1'b1;
      end
    end
  end
endmodule

// ==== hdl/crmc_top.sv ====
// Purpose: mode sequencing, self-clock handling, tick and reset generator
// Assumes: all inputs synchronous to ref_clk; core holds wait/stop request until ack
// Notes: clock gates are enable outputs for the clock tree, not clocks
`timescale 1ns/1ps
module crmc_top
  import crmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic osc_tick,
  input wire logic osc_lost,
  input wire logic osc_quality_ok,
  input wire logic por_evt,
  input wire logic lvr_evt,
  input wire logic illegal_addr_evt,
  input wire logic watchdog_timeout,
  input wire logic irq_any,
  input wire logic wait_req,
  input wire logic stop_req,
  input wire logic tick_rate_wr,
  input wire logic [TICK_RATE_W-1:0] tick_rate_reg,
  input wire logic tick_flag_clr,
  input wire logic selfclock_flag_clr,
  input wire logic synth_select_set,
  input wire logic synth_select_clr,
  input wire logic monitor_enable_wr,
  input wire logic monitor_enable_in,
  input wire logic selfclock_enable_wr,
  input wire logic selfclock_enable_in,
  input wire logic fast_wakeup_wr,
  input wire logic fast_wakeup_in,
  input wire logic pseudo_stop_sel,
  input wire logic tick_in_stop_en,
  input wire logic watchdog_in_stop_en,
  input wire logic synth_stop_in_wait,
  input wire logic tick_stop_in_wait,
  input wire logic watchdog_stop_in_wait,
  input wire logic [WD_RATE_W-1:0] watchdog_rate_field,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic internal_reset,
  output logic [1:0] reset_vector,
  output logic tick_flag,
  output logic selfclock_flag,
  output logic self_clock_mode,
  output logic synth_select,
  output logic monitor_enable,
  output logic selfclock_enable,
  output logic fast_wakeup_en,
  output logic synth_enable,
  output logic osc_enable,
  output logic quality_check_run,
  output logic voltage_regulator_keep,
  output logic core_clk_en,
  output logic sys_clk_en,
  output logic tick_clk_en,
  output logic watchdog_clk_en,
  output logic mode_ack
);
  crmc_mode_e mode;
  crmc_rst_e rstate;
  logic [7:0] rcnt;
  logic mon_pend;
  logic wd_pend;
  logic tick_expire;
  logic fast_wake_scm;
  logic next_tick_run;
  logic reset_evt;
  logic mon_fail;
  logic scm_enter;
  logic scm_exit;

  function automatic logic in_stop(input crmc_mode_e m);
    in_stop = (m == CRMC_STOP) || (m == CRMC_STOP1) || (m == CRMC_STOP2);
  endfunction

  assign mon_fail = osc_lost && monitor_enable && !fast_wake_scm;
  // monitor failure is a reset only with self-clock disabled
  assign reset_evt = !reset_pin_in || por_evt || lvr_evt || illegal_addr_evt
    || (watchdog_timeout && watchdog_rate_field != '0)
    || (mon_fail && !selfclock_enable);
  assign scm_enter = mon_fail && selfclock_enable && !self_clock_mode;
  assign scm_exit = self_clock_mode && !fast_wake_scm && osc_quality_ok;

  // reset generator; the pin drive count absorbs the synchronization cycles
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rstate <= CRMC_RS_DRIVE;
      rcnt <= '0;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b1;
      internal_reset <= 1'b1;
      reset_vector <= VEC_POR_EXT;
    end
    else if (ce)
    begin
      unique case (rstate)
        CRMC_RS_DRIVE:
        begin
          if (rcnt == RST_DRIVE_CYC + RST_SYNC_CYC - 8'h01)
          begin
            rcnt <= '0;
            reset_pin_oe <= 1'b0;
            rstate <= CRMC_RS_SETTLE;
          end
          else
            rcnt <= rcnt + 8'h01;
        end
        CRMC_RS_SETTLE:
        begin
          if (rcnt == RST_SAMPLE_CYC - 8'h01)
          begin
            rcnt <= '0;
            if (!reset_pin_in)
            begin
              reset_vector <= VEC_POR_EXT;
              rstate <= CRMC_RS_HOLD;
            end
            else
            begin
              reset_vector <= mon_pend ? VEC_MONITOR : (wd_pend ? VEC_WATCHDOG : VEC_POR_EXT);
              internal_reset <= 1'b0;
              rstate <= CRMC_RS_DONE;
            end
          end
          else
            rcnt <= rcnt + 8'h01;
        end
        CRMC_RS_HOLD:
        begin
          if (reset_pin_in)
          begin
            internal_reset <= 1'b0;
            rstate <= CRMC_RS_DONE;
          end
        end
        CRMC_RS_DONE:
        begin
          if (reset_evt)
          begin
            rcnt <= '0;
            reset_pin_oe <= 1'b1;
            internal_reset <= 1'b1;
            rstate <= CRMC_RS_DRIVE;
          end
        end
      endcase
    end
  end

  // pending sources remembered until the vector is chosen
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      mon_pend <= 1'b0;
      wd_pend <= 1'b0;
    end
    else if (ce)
    begin
      if (rstate == CRMC_RS_DONE && !reset_evt)
      begin
        mon_pend <= 1'b0;
        wd_pend <= 1'b0;
      end
      else
      begin
        if (mon_fail && !selfclock_enable)
          mon_pend <= 1'b1;
        if (watchdog_timeout && watchdog_rate_field != '0)
          wd_pend <= 1'b1;
      end
    end
  end

  // configuration bits; a monitor reset restores the monitor and self-clock enables at once
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      monitor_enable <= 1'b1;
      selfclock_enable <= 1'b1;
      fast_wakeup_en <= 1'b0;
    end
    else if (ce)
    begin
      if (mon_fail && !selfclock_enable)
      begin
        monitor_enable <= 1'b1;
        selfclock_enable <= 1'b1;
      end
      else
      begin
        if (monitor_enable_wr)
          monitor_enable <= monitor_enable_in;
        if (selfclock_enable_wr)
          selfclock_enable <= selfclock_enable_in;
      end
      if (fast_wakeup_wr)
        fast_wakeup_en <= fast_wakeup_in;
    end
  end

  // self-clock mode tracking; the fast-wake variant keeps the oscillator off
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      self_clock_mode <= 1'b1;
      fast_wake_scm <= 1'b0;
      selfclock_flag <= 1'b0;
      quality_check_run <= 1'b1;
    end
    else if (ce)
    begin
      if (selfclock_flag_clr)
        selfclock_flag <= 1'b0;
      if (mon_fail && !selfclock_enable)
      begin
        self_clock_mode <= 1'b1;
        quality_check_run <= 1'b1;
        selfclock_flag <= 1'b1;
      end
      else if (scm_enter)
      begin
        self_clock_mode <= 1'b1;
        quality_check_run <= 1'b1;
        selfclock_flag <= 1'b1;
      end
      else if (fast_wake_scm && !fast_wakeup_en)
      begin
        fast_wake_scm <= 1'b0;
        quality_check_run <= 1'b1;
      end
      // wake decision goes ahead of the abort, which would otherwise swallow every stop exit
      else if (mode == CRMC_STOP && irq_any && !pseudo_stop_sel)
      begin
        if (fast_wakeup_en && selfclock_enable)
        begin
          self_clock_mode <= 1'b1;
          fast_wake_scm <= 1'b1;
        end
        else
          quality_check_run <= 1'b1;
      end
      else if (in_stop(mode) && !pseudo_stop_sel)
        quality_check_run <= 1'b0;
      else if (scm_exit && quality_check_run)
      begin
        self_clock_mode <= 1'b0;
        quality_check_run <= 1'b0;
        selfclock_flag <= 1'b1;
      end
    end
  end

  // wait and stop sequencing
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      mode <= CRMC_RUN;
      synth_select <= 1'b0;
      synth_enable <= 1'b1;
      core_clk_en <= 1'b1;
      sys_clk_en <= 1'b1;
      mode_ack <= 1'b0;
    end
    else if (ce)
    begin
      mode_ack <= 1'b0;
      if (internal_reset)
      begin
        mode <= CRMC_RUN;
        synth_select <= 1'b0;
        synth_enable <= 1'b1;
        core_clk_en <= 1'b1;
        sys_clk_en <= 1'b1;
      end
      else
      begin
        unique case (mode)
          CRMC_RUN:
          begin
            if (synth_select_set && !self_clock_mode)
              synth_select <= 1'b1;
            else if (synth_select_clr || scm_enter)
              synth_select <= 1'b0;
            if (stop_req && !mode_ack)
            begin
              synth_select <= 1'b0;
              mode <= CRMC_STOP1;
            end
            else if (wait_req && !mode_ack)
            begin
              if (synth_stop_in_wait)
              begin
                synth_select <= 1'b0;
                synth_enable <= 1'b0;
              end
              mode_ack <= 1'b1;
              mode <= CRMC_WAIT;
            end
          end
          CRMC_WAIT:
          begin
            if (irq_any)
            begin
              mode <= CRMC_RUN;
              synth_enable <= 1'b1;
            end
          end
          CRMC_STOP1:
          begin
            // synthesizer kept alive only in pseudo stop while in self-clock mode
            synth_enable <= pseudo_stop_sel && self_clock_mode;
            mode <= CRMC_STOP2;
          end
          CRMC_STOP2:
          begin
            core_clk_en <= 1'b0;
            mode <= CRMC_STOP;
          end
          CRMC_STOP:
          begin
            sys_clk_en <= 1'b0;
            mode_ack <= !sys_clk_en ? 1'b0 : 1'b1;
            if (irq_any)
            begin
              mode <= CRMC_RUN;
              synth_enable <= 1'b1;
              core_clk_en <= 1'b1;
              sys_clk_en <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // clock enables for tick, watchdog and oscillator
  always_comb
  begin
    next_tick_run = 1'b1;
    if (mode == CRMC_WAIT && tick_stop_in_wait)
      next_tick_run = 1'b0;
    else if (in_stop(mode))
      next_tick_run = pseudo_stop_sel && tick_in_stop_en;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tick_clk_en <= 1'b1;
      watchdog_clk_en <= 1'b1;
      osc_enable <= 1'b1;
      voltage_regulator_keep <= 1'b1;
    end
    else if (ce)
    begin
      tick_clk_en <= next_tick_run;
      if (mode == CRMC_WAIT)
        watchdog_clk_en <= !watchdog_stop_in_wait;
      else if (in_stop(mode))
        watchdog_clk_en <= pseudo_stop_sel && watchdog_in_stop_en;
      else
        watchdog_clk_en <= watchdog_rate_field != '0;
      osc_enable <= !fast_wake_scm && !(in_stop(mode) && !pseudo_stop_sel);
      voltage_regulator_keep <= !in_stop(mode) || (pseudo_stop_sel && self_clock_mode);
    end
  end

  crmc_tick u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .count_en(next_tick_run && osc_tick),
    .restart(tick_rate_wr),
    .rate(tick_rate_reg),
    .expire(tick_expire)
  );

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      tick_flag <= 1'b0;
    else if (ce)
    begin
      if (tick_expire)
        tick_flag <= 1'b1;
      else if (tick_flag_clr)
        tick_flag <= 1'b0;
    end
  end

  pin_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(reset_pin_oe) && ce [*1] |-> internal_reset) else $error("pin driven without internal reset");
  release_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(reset_pin_oe) |-> internal_reset [*8]) else $error("internal reset dropped early");
  tick_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && tick_expire |=> tick_flag) else $error("tick flag missed");
  tick_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(tick_flag) |-> $past(tick_flag_clr)) else $error("tick flag cleared without write");
  stop_osc_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && mode == CRMC_STOP && !pseudo_stop_sel |=> !osc_enable) else $error("oscillator on in full stop");
  stop_select_a: assert property (@(posedge ref_clk) disable iff (rst)
    mode == CRMC_STOP2 |-> !synth_select) else $error("select set in stop");
  wait_synth_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && mode == CRMC_RUN && wait_req && synth_stop_in_wait && !mode_ack && !stop_req && !internal_reset
    |=> !synth_enable && !synth_select) else $error("synthesizer not stopped in wait");
  fast_osc_a: assert property (@(posedge ref_clk) disable iff (rst)
    fast_wake_scm |=> !osc_enable || !fast_wake_scm) else $error("oscillator on in fast wake");
endmodule

// ==== tb/crmc_pin_model.sv ====
// Purpose: reset pin with its pull-up and an external holder
// Assumes: pin is open drain, pulled up when nobody drives it low
// Notes: pull-up lifts the pin at once, well inside the settle window
`timescale 1ns/1ps
module crmc_pin_model (
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic ext_hold_low,
  output logic reset_pin_in
);
  assign reset_pin_in = ((reset_pin_oe && !reset_pin_out) || ext_hold_low) ? 1'b0 : 1'b1;
endmodule

// ==== tb/crmc_top_tb_top.sv ====
// Purpose: self-checking bench for the mode and reset controller
// Assumes: inputs change at the falling edge, outputs sampled there
// Notes: sync latency may be 3 to 6 cycles, so reset counts allow that span
`timescale 1ns/1ps
module crmc_top_tb_top;
  import crmc_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, osc_tick = 1'b0, osc_lost = 1'b0, osc_quality_ok = 1'b0;
  logic por_evt = 1'b0, lvr_evt = 1'b0, illegal_addr_evt = 1'b0, watchdog_timeout = 1'b0, irq_any = 1'b0;
  logic wait_req = 1'b0, stop_req = 1'b0, tick_rate_wr = 1'b0, tick_flag_clr = 1'b0, selfclock_flag_clr = 1'b0;
  logic synth_select_set = 1'b0, synth_select_clr = 1'b0, monitor_enable_wr = 1'b0, monitor_enable_in = 1'b1;
  logic selfclock_enable_wr = 1'b0, selfclock_enable_in = 1'b1, fast_wakeup_wr = 1'b0, fast_wakeup_in = 1'b0;
  logic pseudo_stop_sel = 1'b0, tick_in_stop_en = 1'b0, watchdog_in_stop_en = 1'b0, synth_stop_in_wait = 1'b0;
  logic tick_stop_in_wait = 1'b0, watchdog_stop_in_wait = 1'b0, ext_hold_low = 1'b0;
  logic [TICK_RATE_W-1:0] tick_rate_reg = '0;
  logic [WD_RATE_W-1:0] watchdog_rate_field = '0;
  logic reset_pin_in, reset_pin_out, reset_pin_oe, internal_reset, tick_flag, selfclock_flag, self_clock_mode;
  logic synth_select, monitor_enable, selfclock_enable, fast_wakeup_en, synth_enable, osc_enable;
  logic quality_check_run, voltage_regulator_keep, core_clk_en, sys_clk_en, tick_clk_en, watchdog_clk_en, mode_ack;
  logic [1:0] reset_vector;
  int bad_count = 0;
  int checks_done = 0;

  always #20 ref_clk = ~ref_clk;

  crmc_top i_dut (.ref_clk, .rst, .ce, .osc_tick, .osc_lost, .osc_quality_ok, .por_evt, .lvr_evt,
    .illegal_addr_evt, .watchdog_timeout, .irq_any, .wait_req, .stop_req, .tick_rate_wr, .tick_rate_reg,
    .tick_flag_clr, .selfclock_flag_clr, .synth_select_set, .synth_select_clr, .monitor_enable_wr,
    .monitor_enable_in, .selfclock_enable_wr, .selfclock_enable_in, .fast_wakeup_wr, .fast_wakeup_in,
    .pseudo_stop_sel, .tick_in_stop_en, .watchdog_in_stop_en, .synth_stop_in_wait, .tick_stop_in_wait,
    .watchdog_stop_in_wait, .watchdog_rate_field, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
    .internal_reset, .reset_vector, .tick_flag, .selfclock_flag, .self_clock_mode, .synth_select,
    .monitor_enable, .selfclock_enable, .fast_wakeup_en, .synth_enable, .osc_enable, .quality_check_run,
    .voltage_regulator_keep, .core_clk_en, .sys_clk_en, .tick_clk_en, .watchdog_clk_en, .mode_ack);

  crmc_pin_model i_pin (.reset_pin_out, .reset_pin_oe, .ext_hold_low, .reset_pin_in);

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // bounded wait; running out ends the run as a mismatch
  task automatic wait_val(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v)
    begin
      @(negedge ref_clk);
      n++;
      if (n > lim)
      begin
        bad_count++;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, s, v);
        give_verdict();
      end
    end
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  task automatic rst_seq(input logic [1:0] vec);
    int n;
    wait_val(reset_pin_oe, 1'b1, 8, n);
    check({reset_pin_oe, reset_pin_out}, 2'h2);
    wait_val(reset_pin_oe, 1'b0, 200, n);
    check(n >= 131 && n <= 134, 1'b1);
    check(internal_reset, 1'b1);
    wait_val(internal_reset, 1'b0, 100, n);
    check(n >= 64 && n <= 66, 1'b1);
    check(reset_vector, vec);
  endtask

  task automatic t_por();
    int n;
    cyc(2);
    rst = 1'b0;
    rst_seq(VEC_POR_EXT);
    check({monitor_enable, selfclock_enable, self_clock_mode}, 3'h7);
    osc_quality_ok = 1'b1;
    wait_val(self_clock_mode, 1'b0, 50, n);
    cyc(1);
    check(selfclock_flag, 1'b1);
    pulse(selfclock_flag_clr);
    cyc(1);
    check(selfclock_flag, 1'b0);
    fast_wakeup_in = 1'b0;
    pulse(fast_wakeup_wr);
    $display("test por done");
  endtask

  task automatic t_wdog();
    pulse(watchdog_timeout);
    cyc(4);
    check(reset_pin_oe, 1'b0);
    check(watchdog_clk_en, 1'b0);
    watchdog_rate_field = 3'h3;
    pulse(watchdog_timeout);
    rst_seq(VEC_WATCHDOG);
    $display("test watchdog done");
  endtask

  task automatic t_ext();
    int n;
    ext_hold_low = 1'b1;
    wait_val(reset_pin_oe, 1'b1, 8, n);
    cyc(250);
    check(internal_reset, 1'b1);
    ext_hold_low = 1'b0;
    wait_val(internal_reset, 1'b0, 300, n);
    check(reset_vector, VEC_POR_EXT);
    $display("test external done");
  endtask

  task automatic t_wait();
    int n;
    pulse(synth_select_set);
    cyc(1);
    check(synth_select, 1'b1);
    synth_stop_in_wait = 1'b1;
    tick_stop_in_wait = 1'b1;
    watchdog_stop_in_wait = 1'b1;
    wait_req = 1'b1;
    wait_val(mode_ack, 1'b1, 10, n);
    wait_req = 1'b0;
    cyc(1);
    check({synth_select, synth_enable}, 2'h0);
    check({tick_clk_en, watchdog_clk_en}, 2'h0);
    pulse(irq_any);
    wait_val(synth_enable, 1'b1, 10, n);
    tick_stop_in_wait = 1'b0;
    watchdog_stop_in_wait = 1'b0;
    cyc(1);
    check({tick_clk_en, watchdog_clk_en}, 2'h3);
    $display("test wait done");
  endtask

  task automatic t_stop();
    int n;
    synth_stop_in_wait = 1'b0;
    pulse(synth_select_set);
    stop_req = 1'b1;
    wait_val(mode_ack, 1'b1, 10, n);
    stop_req = 1'b0;
    wait_val(sys_clk_en, 1'b0, 10, n);
    check({synth_select, synth_enable, core_clk_en}, 3'h0);
    check({osc_enable, monitor_enable && osc_enable}, 2'h0);
    check(voltage_regulator_keep, 1'b0);
    pulse(irq_any);
    wait_val(core_clk_en, 1'b1, 100, n);
    check(synth_select, 1'b0);
    check(quality_check_run, 1'b1);
    $display("test stop done");
  endtask

  task automatic t_fast();
    int n;
    fast_wakeup_in = 1'b1;
    pulse(fast_wakeup_wr);
    check(fast_wakeup_en, 1'b1);
    stop_req = 1'b1;
    wait_val(mode_ack, 1'b1, 10, n);
    stop_req = 1'b0;
    pulse(irq_any);
    check({self_clock_mode, selfclock_flag}, 2'h2);
    cyc(1);
    check(osc_enable, 1'b0);
    fast_wakeup_in = 1'b0;
    pulse(fast_wakeup_wr);
    wait_val(self_clock_mode, 1'b0, 10, n);
    check({selfclock_flag, osc_enable}, 2'h3);
    pulse(selfclock_flag_clr);
    $display("test fast wake done");
  endtask

  task automatic t_tick();
    int n;
    osc_tick = 1'b1;
    tick_rate_reg = 4'h1;
    pulse(tick_rate_wr);
    wait_val(tick_flag, 1'b1, 20, n);
    pulse(tick_flag_clr);
    check(tick_flag, 1'b0);
    wait_val(tick_flag, 1'b1, 20, n);
    check(n >= 6 && n <= 10, 1'b1);
    tick_rate_reg = 4'h0;
    pulse(tick_rate_wr);
    pulse(tick_flag_clr);
    cyc(40);
    check(tick_flag, 1'b0);
    $display("test tick done");
  endtask

  initial
  begin
    t_por();
    t_wdog();
    t_ext();
    t_wait();
    t_stop();
    t_fast();
    t_tick();
    give_verdict();
  end
endmodule
